// ===== hw/two_level_interrupt_priority.v
// Two-level interrupt arbiter and vector generator for the core.
`timescale 1ns/1ns
`default_nettype none
`include "irq_prio_consts.vh"
module two_level_interrupt_priority #(
    parameter N = 11
) (
    // Clock and reset.
    input  wire        sys_clk,
    input  wire        srst,
    // Register write port from the core.
    input  wire        primary_enable_we,
    input  wire        primary_priority_we,
    input  wire        secondary_we,
    input  wire [7:0]  write_data,
    // Request sources, level high while pending.
    input  wire        supply_monitor_request,
    input  wire        watchdog_request,
    input  wire        external_request_0,
    input  wire        converter_request,
    input  wire        timer0_overflow_request,
    input  wire        external_request_1,
    input  wire        timer1_overflow_request,
    input  wire        two_wire_request,
    input  wire        four_wire_request,
    input  wire        uart_receive_request,
    input  wire        uart_transmit_request,
    input  wire        timer2_overflow_request,
    input  wire        timer2_external_flag,
    input  wire        interval_counter_request,
    // Core handshake.
    input  wire        core_ready,
    input  wire [15:0] current_pc,
    input  wire        return_from_irq,
    // Register read-back.
    output reg  [7:0]  primary_enable,
    output reg  [7:0]  primary_priority,
    output reg  [7:0]  secondary_irq_enable_priority,
    // Vectoring to the core.
    output reg         push_strobe,
    output reg  [15:0] push_pc,
    output reg         vector_strobe,
    output reg  [15:0] vector_pc,
    output reg  [3:0]  active_source,
    output reg         high_active,
    output reg         low_active
);
    // ******************************************************
    // Request gathering.
    // ******************************************************
    wire [N-1:0] raw_req;
    wire [N-1:0] enable_vec;
    wire [N-1:0] prio_vec;
    wire [N-1:0] gated;
    wire [7:0]   pe;
    wire [7:0]   pp;
    wire [7:0]   sp;
    assign pe = primary_enable;
    assign pp = primary_priority;
    assign sp = secondary_irq_enable_priority;

    assign raw_req = {interval_counter_request,
                      timer2_overflow_request | timer2_external_flag,
                      uart_receive_request | uart_transmit_request,
                      two_wire_request | four_wire_request,
                      timer1_overflow_request,
                      external_request_1,
                      timer0_overflow_request,
                      converter_request,
                      external_request_0,
                      watchdog_request,
                      supply_monitor_request};
    // The watchdog has no enable or priority bit, so it is enabled at low level whenever the global enable bit is set.
    assign enable_vec = {sp[`INTERVAL_ENABLE_BIT],
                         pe[`TIMER2_BIT], pe[`UART_BIT],
                         sp[`SERIAL_ENABLE_BIT],
                         pe[`TIMER1_BIT], pe[`EXT1_BIT], pe[`TIMER0_BIT],
                         pe[`CONVERTER_BIT], pe[`EXT0_BIT], 1'b1,
                         sp[`SUPPLY_ENABLE_BIT]};
    assign prio_vec = {sp[`INTERVAL_PRIORITY_BIT],
                       pp[`TIMER2_BIT], pp[`UART_BIT],
                       sp[`SERIAL_PRIORITY_BIT],
                       pp[`TIMER1_BIT], pp[`EXT1_BIT], pp[`TIMER0_BIT],
                       pp[`CONVERTER_BIT], pp[`EXT0_BIT], 1'b0,
                       sp[`SUPPLY_PRIORITY_BIT]};
    assign gated = raw_req & enable_vec & {N{pe[`GLOBAL_ENABLE_BIT]}};

    // ******************************************************
    // Per-level polling.
    // ******************************************************
    wire       hi_found;
    wire       lo_found;
    wire [3:0] hi_index;
    wire [3:0] lo_index;
    irq_poll_select #(.N(N)) u_high (
        .pending (gated & prio_vec),
        .found   (hi_found),
        .index   (hi_index)
    );
    irq_poll_select #(.N(N)) u_low (
        .pending (gated & ~prio_vec),
        .found   (lo_found),
        .index   (lo_index)
    );

    function [15:0] vector_of;
        input [3:0] src;
        begin
            case (src)
                `SRC_SUPPLY:    vector_of = `VEC_SUPPLY;
                `SRC_WATCHDOG:  vector_of = `VEC_WATCHDOG;
                `SRC_EXT0:      vector_of = `VEC_EXT0;
                `SRC_CONVERTER: vector_of = `VEC_CONVERTER;
                `SRC_TIMER0:    vector_of = `VEC_TIMER0;
                `SRC_EXT1:      vector_of = `VEC_EXT1;
                `SRC_TIMER1:    vector_of = `VEC_TIMER1;
                `SRC_SERIAL:    vector_of = `VEC_SERIAL;
                `SRC_UART:      vector_of = `VEC_UART;
                `SRC_TIMER2:    vector_of = `VEC_TIMER2;
                `SRC_INTERVAL:  vector_of = `VEC_INTERVAL;
                default:        vector_of = 16'h0000;
            endcase
        end
    endfunction

    // ******************************************************
    // Acceptance sequencer.
    // ******************************************************
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_PUSH = 3'b010;
    localparam [2:0] ST_JUMP = 3'b100;
    reg [2:0]  state;
    reg [3:0]  pick;
    reg        pick_high;
    reg        take;
    reg        take_high;
    reg [3:0]  take_index;

    always @* begin
        take       = 1'b0;
        take_high  = 1'b0;
        take_index = 4'h0;
        if (hi_found && !high_active) begin
            take       = 1'b1;
            take_high  = 1'b1;
            take_index = hi_index;
        end else if (lo_found && !high_active && !low_active) begin
            take       = 1'b1;
            take_index = lo_index;
        end
    end

    always @(posedge sys_clk) begin
        if (srst) begin
            primary_enable                <= `PRIMARY_ENABLE_RESET;
            primary_priority              <= `PRIMARY_PRIORITY_RESET;
            secondary_irq_enable_priority <= `SECONDARY_RESET;
            state         <= ST_IDLE;
            pick          <= 4'h0;
            pick_high     <= 1'b0;
            push_strobe   <= 1'b0;
            push_pc       <= 16'h0000;
            vector_strobe <= 1'b0;
            vector_pc     <= 16'h0000;
            active_source <= 4'h0;
            high_active   <= 1'b0;
            low_active    <= 1'b0;
        end else begin
            push_strobe   <= 1'b0;
            vector_strobe <= 1'b0;
            if (primary_enable_we) begin
                primary_enable <= write_data;
            end
            if (primary_priority_we) begin
                primary_priority <= write_data;
            end
            if (secondary_we) begin
                secondary_irq_enable_priority <= write_data;
            end
            case (state)
                ST_IDLE: begin
                    if (return_from_irq) begin
                        if (high_active) begin
                            high_active <= 1'b0;
                        end else begin
                            low_active <= 1'b0;
                        end
                    end else if (take && core_ready) begin
                        pick      <= take_index;
                        pick_high <= take_high;
                        push_pc     <= current_pc;
                        push_strobe <= 1'b1;
                        state       <= ST_PUSH;
                    end
                end
                ST_PUSH: begin
                    vector_pc     <= vector_of(pick);
                    vector_strobe <= 1'b1;
                    active_source <= pick;
                    if (pick_high) begin
                        high_active <= 1'b1;
                    end else begin
                        low_active <= 1'b1;
                    end
                    state <= ST_JUMP;
                end
                ST_JUMP: begin
                    state <= ST_IDLE;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end
endmodule // two_level_interrupt_priority
`default_nettype wire

// ===== hw/irq_prio_consts.vh
// Constants for the two-level interrupt priority controller.
// Functional notes
// - Secondary register bits 2, 1 and 0 enable the interval counter, supply monitor and serial sync requests.
// - Secondary register bits 6, 5 and 4 set the priority of the interval counter, supply monitor and serial sync requests.
// - Every source except the watchdog has its own enable bit and one of two priority levels; the watchdog is enabled at low level by global enable only.
// - An enabled high priority request may preempt a low priority service routine in progress.
// - When high and low requests arrive together the high one is served first.
// - A running service routine is never preempted by a request of its own level.
// - Same-level order starts supply monitor, then watchdog, external 0, converter, timer 0, external 1, timer 1.
// - The order continues with serial sync, UART, timer 2, and lowest of all the interval counter.
// - On acceptance the current program counter is pushed onto the stack before the jump.
// - Vectors are 0003H external 0, 000BH timer 0, 0013H external 1, 001BH timer 1, 0023H UART, 002BH timer 2.
// - Vectors are 0033H converter, 003BH serial sync, 0043H supply monitor, 0053H interval counter, 005BH watchdog.
// - Primary enable bit 7 is a global enable that blocks every source when it is 0.
`ifndef IRQ_PRIO_CONSTS_VH
`define IRQ_PRIO_CONSTS_VH
// Register reset values.
`define PRIMARY_ENABLE_RESET    8'h00
`define PRIMARY_PRIORITY_RESET  8'h00
`define SECONDARY_RESET         8'ha0
// Primary enable field positions.
`define GLOBAL_ENABLE_BIT       7
`define CONVERTER_BIT           6
`define TIMER2_BIT              5
`define UART_BIT                4
`define TIMER1_BIT              3
`define EXT1_BIT                2
`define TIMER0_BIT              1
`define EXT0_BIT                0
// Secondary register field positions.
`define INTERVAL_PRIORITY_BIT   6
`define SUPPLY_PRIORITY_BIT     5
`define SERIAL_PRIORITY_BIT     4
`define MUST_BE_ZERO_BIT        3
`define INTERVAL_ENABLE_BIT     2
`define SUPPLY_ENABLE_BIT       1
`define SERIAL_ENABLE_BIT       0
// Source indices in polling order, 0 polled first.
`define SRC_SUPPLY              4'h0
`define SRC_WATCHDOG            4'h1
`define SRC_EXT0                4'h2
`define SRC_CONVERTER           4'h3
`define SRC_TIMER0              4'h4
`define SRC_EXT1                4'h5
`define SRC_TIMER1              4'h6
`define SRC_SERIAL              4'h7
`define SRC_UART                4'h8
`define SRC_TIMER2              4'h9
`define SRC_INTERVAL            4'ha
// Vector addresses.
`define VEC_EXT0                16'h0003
`define VEC_TIMER0              16'h000b
`define VEC_EXT1                16'h0013
`define VEC_TIMER1              16'h001b
`define VEC_UART                16'h0023
`define VEC_TIMER2              16'h002b
`define VEC_CONVERTER           16'h0033
`define VEC_SERIAL              16'h003b
`define VEC_SUPPLY              16'h0043
`define VEC_INTERVAL            16'h0053
`define VEC_WATCHDOG            16'h005b
`endif

// ===== hw/irq_poll_select.v
// Fixed-order poll that picks the first pending source of one level.
`timescale 1ns/1ns
`default_nettype none
module irq_poll_select #(
    parameter N = 11
) (
    // Pending requests, index 0 polled first.
    input  wire [N-1:0] pending,
    // Result.
    output reg          found,
    output reg  [3:0]   index
);
    integer i;
    always @* begin
        found = 1'b0;
        index = 4'h0;
        for (i = N - 1; i >= 0; i = i - 1) begin
            if (pending[i]) begin
                found = 1'b1;
                index = i[3:0];
            end
        end
    end
endmodule // irq_poll_select
`default_nettype wire

// ===== verif/irq_prio_props.sv
// Port-level assertions for the two-level interrupt arbiter.
`timescale 1ns/1ns
`default_nettype none
module irq_prio_props #(
    parameter N = 11
) (
    // Clock, reset and inputs.
    input wire logic        sys_clk, srst, secondary_we, watchdog_request, return_from_irq,
    input wire logic [7:0]  write_data,
    input wire logic [15:0] current_pc,
    // Outputs.
    input wire logic        push_strobe, vector_strobe, high_active, low_active,
    input wire logic [7:0]  primary_enable, secondary_irq_enable_priority,
    input wire logic [15:0] push_pc, vector_pc,
    input wire logic [3:0]  active_source
);
    localparam logic [175:0] VEC = {16'h0053, 16'h002b, 16'h0023, 16'h003b, 16'h001b,
        16'h0013, 16'h000b, 16'h0033, 16'h0003, 16'h005b, 16'h0043};
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    sequence s_accept;
        push_strobe ##1 (vector_strobe && !push_strobe) ##1 !vector_strobe;
    endsequence
    sequence s_idle_ret;
        return_from_irq && !push_strobe && !vector_strobe;
    endsequence
    property p_accept; push_strobe |-> s_accept; endproperty
    a_accept: assert property (p_accept) else $error("push not followed by one vector");
    property p_push_pc; push_strobe |-> push_pc == $past(current_pc); endproperty
    a_push_pc: assert property (p_push_pc) else $error("pushed pc wrong");
    property p_vec_map; vector_strobe |-> vector_pc == VEC[{active_source, 4'h0} +: 16]; endproperty
    a_vec_map: assert property (p_vec_map) else $error("vector address wrong");
    property p_global; push_strobe |-> $past(primary_enable[7]); endproperty
    a_global: assert property (p_global) else $error("accepted while globally off");
    property p_wd_src;
        vector_strobe && active_source == 4'h1 |-> $past(watchdog_request, 2) && low_active;
    endproperty
    a_wd_src: assert property (p_wd_src) else $error("watchdog vector without request");
    property p_same_high; push_strobe |-> !$past(high_active); endproperty
    a_same_high: assert property (p_same_high) else $error("high service preempted");
    property p_low_preempt; vector_strobe && $past(low_active, 2) |-> high_active; endproperty
    a_low_preempt: assert property (p_low_preempt) else $error("low preempted by low");
    property p_return;
        s_idle_ret |=> ($past(high_active) ? (!high_active && low_active == $past(low_active))
                                          : !low_active);
    endproperty
    a_return: assert property (p_return) else $error("return left level state wrong");
    property p_sec_wr;
        secondary_we |=> secondary_irq_enable_priority == $past(write_data);
    endproperty
    a_sec_wr: assert property (p_sec_wr) else $error("secondary write lost");
endmodule // irq_prio_props
`default_nettype wire

// ===== verif/core_model.sv
// Behavioural core that pushes, jumps and returns around the arbiter.
`timescale 1ns/1ns
`default_nettype none
module core_model (
    // Clock, reset and bench controls.
    input  wire logic        sys_clk, srst, ret_req, stall,
    // Arbiter outputs.
    input  wire logic        push_strobe, vector_strobe,
    input  wire logic [15:0] push_pc, vector_pc,
    // Core outputs.
    output wire logic        core_ready,
    output var  logic        return_from_irq,
    output var  logic [15:0] current_pc
);
    logic [15:0] stack [$];
    assign core_ready = !stall;
    always @(posedge sys_clk) begin
        if (srst) begin
            current_pc <= 16'h0100;
            return_from_irq <= 1'b0;
            stack.delete();
        end else begin
            return_from_irq <= ret_req && (stack.size() > 0);
            if (push_strobe) stack.push_back(push_pc);
            if (vector_strobe) current_pc <= vector_pc;
            else if (return_from_irq) current_pc <= stack.pop_back();
            else current_pc <= current_pc + 16'h0001;
        end
    end
endmodule // core_model
`default_nettype wire

// ===== verif/testbench.sv
// Self-checking bench for the two-level interrupt arbiter.
`timescale 1ns/1ns
`default_nettype none
module testbench;
    localparam logic [175:0] VEC = {16'h0053, 16'h002b, 16'h0023, 16'h003b, 16'h001b,
        16'h0013, 16'h000b, 16'h0033, 16'h0003, 16'h005b, 16'h0043};
    logic        sys_clk = 1'b0, srst = 1'b1, pe_we = 1'b0, pp_we = 1'b0, sec_we = 1'b0;
    logic        ret_req = 1'b0, stall = 1'b0;
    logic [7:0]  wdata = 8'h00, d;
    logic [13:0] req = 14'h0000;
    logic [19:0] e;
    logic [19:0] expq [$];
    wire         ready, ret_irq, push_s, vec_s, hi_act, lo_act;
    wire  [15:0] cur_pc, push_pc, vec_pc;
    wire  [7:0]  pe, pp, sec;
    wire  [3:0]  src;
    int          fails = 0, n_compared = 0, r;
    always #50 sys_clk = ~sys_clk;
    two_level_interrupt_priority #(.N(11)) DUT (.sys_clk(sys_clk), .srst(srst),
        .primary_enable_we(pe_we), .primary_priority_we(pp_we), .secondary_we(sec_we),
        .write_data(wdata), .supply_monitor_request(req[0]), .watchdog_request(req[1]),
        .external_request_0(req[2]), .converter_request(req[3]),
        .timer0_overflow_request(req[4]), .external_request_1(req[5]),
        .timer1_overflow_request(req[6]), .two_wire_request(req[7]),
        .four_wire_request(req[8]), .uart_receive_request(req[9]),
        .uart_transmit_request(req[10]), .timer2_overflow_request(req[11]),
        .timer2_external_flag(req[12]), .interval_counter_request(req[13]),
        .core_ready(ready), .current_pc(cur_pc), .return_from_irq(ret_irq),
        .primary_enable(pe), .primary_priority(pp), .secondary_irq_enable_priority(sec),
        .push_strobe(push_s), .push_pc(push_pc), .vector_strobe(vec_s), .vector_pc(vec_pc),
        .active_source(src), .high_active(hi_act), .low_active(lo_act));
    core_model u_core (.sys_clk(sys_clk), .srst(srst), .ret_req(ret_req), .stall(stall),
        .push_strobe(push_s), .vector_strobe(vec_s), .push_pc(push_pc), .vector_pc(vec_pc),
        .core_ready(ready), .return_from_irq(ret_irq), .current_pc(cur_pc));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic wr(input int k, input logic [7:0] v);
        wdata = v;
        pe_we = (k == 0);
        pp_we = (k == 1);
        sec_we = (k == 2);
        cyc(1);
        {pe_we, pp_we, sec_we} = 3'b000;
        cyc(1);
    endtask
    task automatic expect_src(input logic [3:0] s);
        expq.push_back({s, VEC[{s, 4'h0} +: 16]});
    endtask
    // Waits for the next vector, then withdraws the served request bits.
    task automatic serve(input logic [13:0] m);
        int k;
        k = 0;
        while (vec_s !== 1'b1 && k < 20) begin
            cyc(1);
            k++;
        end
        if (k == 20) begin
            fails++;
            $display("CHECK FAILED at %0t: no vector", $time);
        end
        req = req & ~m;
        cyc(1);
    endtask
    task automatic ret;
        ret_req = 1'b1;
        cyc(1);
        ret_req = 1'b0;
        cyc(3);
    endtask
    function automatic logic [13:0] mask_of(input int s);
        if (s < 7) return 14'h0001 << s;
        if (s == 10) return 14'h2000;
        return 14'h0003 << (2 * s - 7);
    endfunction
    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge sys_clk) if (vec_s === 1'b1) begin
        if (expq.size() == 0) begin
            fails++;
            $display("CHECK FAILED at %0t: unexpected vector", $time);
        end else begin
            e = expq.pop_front();
            chk(vec_pc, e[15:0]);
            chk({12'h000, src}, {12'h000, e[19:16]});
        end
    end
    initial begin
        repeat (3000) @(posedge sys_clk);
        fails++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        tally_and_finish();
    end
    initial begin
        r = $urandom(32'hfcc3);
        cyc(10);
        srst = 1'b0;
        chk({pe, pp}, 16'h0000);
        chk({8'h00, sec}, 16'h00a0);
        for (int i = 0; i < 12; i++) begin
            d = 8'($urandom);
            if (i % 3 == 2) d[3] = 1'b0;
            wr(i % 3, d);
            chk({8'h00, (i % 3 == 0) ? pe : (i % 3 == 1) ? pp : sec}, {8'h00, d});
        end
        $display("register test done");
        wr(0, 8'hff);
        wr(1, 8'h00);
        wr(2, 8'h07);
        req = 14'h3fff;
        for (int i = 0; i < 11; i++) begin
            expect_src(4'(i));
            serve(mask_of(i));
            ret();
        end
        $display("polling order test done");
        wr(1, 8'h05);
        expect_src(4'h5);
        req = 14'h0030;
        serve(14'h0020);
        req[2] = 1'b1;
        cyc(8);
        expect_src(4'h2);
        ret();
        serve(14'h0004);
        expect_src(4'h4);
        ret();
        serve(14'h0010);
        expect_src(4'h5);
        req[5] = 1'b1;
        serve(14'h0020);
        ret();
        ret();
        $display("preemption test done");
        wr(0, 8'h02);
        wr(2, 8'h00);
        req = 14'h2010;
        cyc(8);
        stall = 1'b1;
        wr(0, 8'h82);
        cyc(8);
        expect_src(4'h4);
        stall = 1'b0;
        serve(14'h0010);
        ret();
        cyc(8);
        wr(2, 8'h44);
        req[4] = 1'b1;
        expect_src(4'ha);
        serve(14'h2000);
        expect_src(4'h4);
        ret();
        serve(14'h0010);
        ret();
        $display("gating test done");
        chk(16'(expq.size()), 16'h0000);
        tally_and_finish();
    end
endmodule // testbench
bind two_level_interrupt_priority irq_prio_props #(.N(N)) u_props (.sys_clk(sys_clk),
    .srst(srst), .secondary_we(secondary_we), .watchdog_request(watchdog_request),
    .return_from_irq(return_from_irq), .write_data(write_data), .current_pc(current_pc),
    .push_strobe(push_strobe), .vector_strobe(vector_strobe), .high_active(high_active),
    .low_active(low_active), .primary_enable(primary_enable), .push_pc(push_pc),
    .secondary_irq_enable_priority(secondary_irq_enable_priority),
    .vector_pc(vector_pc), .active_source(active_source));
`default_nettype wire
